// ---- design/vrmc_ctrl.sv ----
// Voltage routine mode control with a classic Wishbone register slave.
//=====================================================================
// Contract
// - only one routine mode runs at once
// - override preempts all, ends idle awaiting host
// - demand request never preempts demand or override
// - override preempts periodic at any point
// - status shows request, latch, override, active
// - latch plus enable idle locks periodic activity
// - request implies active; active implies request, enable or override
// - coulomb counting delays cell step to pulse
// - cell and stack steps always run
// - optional steps only if enabled same write
// - request reads high until routine completes
// - repeated requests ignored while request high
// - demand steps use demand filter field
// - result registers update at step completion
// - fresh flag set on store, cleared on read
// - request during override discarded, bits zero
// - active flag high only during active portion
`timescale 1ns/100ps
`include "vrmc_defs.svh"
module vrmc_ctrl (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave.
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [5:2] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic err_o,
	// Override and coulomb counter events.
	input wire logic override_req_i,
	input wire logic override_done_i,
	input wire logic cur_soc_pulse_i,
	// Conversion result input.
	input wire logic [15:0] adc_data_i,
	// Step outputs.
	output logic [2:0] step_o,
	output logic [2:0] filt_o,
	output logic active_o
);
	//=====================================================================
	// Registers.
	logic req_r, per_r, auxm_r, auxt_r, cellt_r, balt_r, hardware_self_check_enable_r, ccen_r, ovl_r, ovr_r, ack_r;
	logic [2:0] filt_r;
	vrmc_pkg::vrmc_step_e step_r, step_nxt;
	vrmc_pkg::vrmc_mode_e mode_r;
	logic [`VRMC_FRESH_BIT:0] res_r [`VRMC_NRES];
	logic [31:0] dat_r;
	logic tstart_r;
	wire tdone_w;

	//=====================================================================
	// Bus decode.
	wire acc_w = cyc_i && stb_i && !ack_r;
	wire wr_w = acc_w && we_i;
	wire rd_w = acc_w && !we_i;
	wire hit_ctrl_w = adr_i == `VRMC_ADR_CTRL;
	wire hit_stat_w = adr_i == `VRMC_ADR_STAT;
	wire [3:0] ridx_w = adr_i - `VRMC_ADR_CELL;
	wire hit_res_w = (adr_i >= `VRMC_ADR_CELL) && (adr_i <= `VRMC_ADR_DIAGNOSTIC_STEP_BITS);
	wire mapped_w = hit_ctrl_w || hit_stat_w || hit_res_w;
	wire wctrl_w = wr_w && hit_ctrl_w && sel_i[0];
	wire wctrl1_w = wr_w && hit_ctrl_w && sel_i[1];
	wire ovr_on_w = ovr_r || override_req_i;
	// A request written together with the coulomb enable must already wait for the current pulse.
	wire ccen_now_w = wctrl1_w ? dat_i[`VRMC_B_CCEN] : ccen_r;
	// Fresh request only when no demand or override owns the routine.
	wire start_w = wctrl_w && dat_i[`VRMC_B_REQ] && !req_r && !ovr_on_w;
	wire idle_w = step_r == vrmc_pkg::VRMC_IDLE;
	wire per_go_w = per_r && !ovl_r && idle_w && !req_r && !ovr_on_w;
	wire active_w = !idle_w;
	assign ack_o = ack_r;
	assign err_o = 1'b0;
	assign dat_o = dat_r;
	assign active_o = active_w || ovr_r;
	assign step_o = step_r;
	assign filt_o = filt_r;
	wire [31:0] ctrl_rd_w = {20'h0_0000, filt_r, ccen_r, 1'b0, hardware_self_check_enable_r, balt_r, cellt_r, auxt_r, auxm_r, per_r, req_r};
	// Request bit read straight from req_r, not gated by the active phase.
	wire [31:0] stat_rd_w = {28'h000_0000, active_o, ovr_r, ovl_r, req_r};

	//=====================================================================
	// Step sequencer.
	always_comb begin
		step_nxt = step_r;
		case (step_r)
			vrmc_pkg::VRMC_IDLE: begin
				if (start_w || per_go_w) step_nxt = ccen_now_w ? vrmc_pkg::VRMC_SYNC : vrmc_pkg::VRMC_CELL;
			end
			vrmc_pkg::VRMC_SYNC: begin
				if (cur_soc_pulse_i) step_nxt = vrmc_pkg::VRMC_CELL;
			end
			vrmc_pkg::VRMC_CELL: begin
				if (tdone_w) step_nxt = vrmc_pkg::VRMC_STACK;
			end
			vrmc_pkg::VRMC_STACK: begin
				if (tdone_w) step_nxt = auxm_r ? vrmc_pkg::VRMC_AUXM : auxt_r ? vrmc_pkg::VRMC_AUXT :
					cellt_r ? vrmc_pkg::VRMC_CELLT : balt_r ? vrmc_pkg::VRMC_BALT : vrmc_pkg::VRMC_IDLE;
			end
			vrmc_pkg::VRMC_AUXM: begin
				if (tdone_w) step_nxt = auxt_r ? vrmc_pkg::VRMC_AUXT : cellt_r ? vrmc_pkg::VRMC_CELLT :
					balt_r ? vrmc_pkg::VRMC_BALT : vrmc_pkg::VRMC_IDLE;
			end
			vrmc_pkg::VRMC_AUXT: begin
				if (tdone_w) step_nxt = cellt_r ? vrmc_pkg::VRMC_CELLT : balt_r ? vrmc_pkg::VRMC_BALT :
					vrmc_pkg::VRMC_IDLE;
			end
			vrmc_pkg::VRMC_CELLT: begin
				if (tdone_w) step_nxt = balt_r ? vrmc_pkg::VRMC_BALT : vrmc_pkg::VRMC_IDLE;
			end
			vrmc_pkg::VRMC_BALT: begin
				if (tdone_w) step_nxt = vrmc_pkg::VRMC_IDLE;
			end
			default: step_nxt = vrmc_pkg::VRMC_IDLE;
		endcase
		// Override wins over every mode.
		if (ovr_on_w) step_nxt = vrmc_pkg::VRMC_IDLE;
	end

	wire tstart_nxt = (step_nxt != step_r) && (step_nxt != vrmc_pkg::VRMC_IDLE) && (step_nxt != vrmc_pkg::VRMC_SYNC);
	wire done_w = (step_r != vrmc_pkg::VRMC_IDLE) && (step_nxt == vrmc_pkg::VRMC_IDLE);

	vrmc_step_timer u_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(tstart_r),
		.filt_i(filt_r),
		.done_o(tdone_w)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			step_r <= vrmc_pkg::VRMC_IDLE;
			tstart_r <= 1'b0;
		end else begin
			step_r <= tstart_r ? step_r : step_nxt;
			tstart_r <= tstart_r ? 1'b0 : tstart_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_r <= vrmc_pkg::VRMC_M_NONE;
		end else if (ovr_on_w) begin
			mode_r <= vrmc_pkg::VRMC_M_OVERRIDE;
		end else if (start_w) begin
			mode_r <= vrmc_pkg::VRMC_M_DEMAND;
		end else if (per_go_w) begin
			mode_r <= vrmc_pkg::VRMC_M_PERIODIC;
		end else if (idle_w) begin
			mode_r <= vrmc_pkg::VRMC_M_NONE;
		end
	end

	//=====================================================================
	// Control register and override tracking.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			req_r <= 1'b0;
			per_r <= 1'b0;
			{auxm_r, auxt_r, cellt_r, balt_r, hardware_self_check_enable_r} <= 5'h00;
			ccen_r <= 1'b0;
			filt_r <= `VRMC_FILT_RST;
			ovr_r <= 1'b0;
			ovl_r <= 1'b0;
		end else begin
			if (override_req_i) ovr_r <= 1'b1;
			else if (override_done_i) ovr_r <= 1'b0;
			// Set wins over the host clear.
			if (override_req_i) ovl_r <= 1'b1;
			else if (wctrl_w && dat_i[`VRMC_B_OVLCLR]) ovl_r <= 1'b0;
			if (wctrl_w) per_r <= dat_i[`VRMC_B_PER];
			if (wctrl1_w) ccen_r <= dat_i[`VRMC_B_CCEN];
			if (wctrl1_w) filt_r <= dat_i[`VRMC_F_FILT_HI:`VRMC_F_FILT_LO];
			if (ovr_on_w) begin
				req_r <= 1'b0;
				{auxm_r, auxt_r, cellt_r, balt_r, hardware_self_check_enable_r} <= 5'h00;
			end else if (start_w) begin
				req_r <= 1'b1;
				{auxm_r, auxt_r, cellt_r, balt_r, hardware_self_check_enable_r} <= {dat_i[`VRMC_B_AUXM], dat_i[`VRMC_B_AUXT],
					dat_i[`VRMC_B_CELLT], dat_i[`VRMC_B_BALT], dat_i[`VRMC_B_HARDWARE_SELF_CHECK_ENABLE]};
			end else if (done_w) begin
				req_r <= 1'b0;
				{auxm_r, auxt_r, cellt_r, balt_r, hardware_self_check_enable_r} <= 5'h00;
			end
		end
	end

	//=====================================================================
	// Result registers with fresh flags.
	genvar gi;
	generate
		for (gi = 0; gi < `VRMC_NRES; gi++) begin : g_res
			wire store_w = tdone_w && (mode_r != vrmc_pkg::VRMC_M_OVERRIDE) &&
				(step_r == vrmc_pkg::vrmc_step_e'(3'(gi + 2)));
			wire read_w = rd_w && hit_res_w && (ridx_w == 4'(gi));
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					res_r[gi] <= 17'h0_0000;
				end else if (store_w) begin
					res_r[gi] <= {1'b1, adc_data_i};
				end else if (read_w) begin
					res_r[gi][`VRMC_FRESH_BIT] <= 1'b0;
				end
			end
		end
	endgenerate

	//=====================================================================
	// Bus answer one cycle after the request.
	wire [31:0] res_rd_w = {15'h0000, res_r[ridx_w[1:0]]};
	wire [31:0] rd_mux_w = !mapped_w ? 32'h0000_0000 : hit_ctrl_w ? ctrl_rd_w : hit_stat_w ? stat_rd_w : res_rd_w;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= 32'h0000_0000;
		end else begin
			ack_r <= acc_w;
			if (rd_w) dat_r <= rd_mux_w;
		end
	end
endmodule

// ---- design/vrmc_defs.svh ----
// Register offsets, field positions, reset values and timing counts of the routine mode controller.
`ifndef VRMC_DEFS_SVH
`define VRMC_DEFS_SVH
`define VRMC_ADR_CTRL 4'h0
`define VRMC_ADR_STAT 4'h1
`define VRMC_ADR_CELL 4'h2
`define VRMC_ADR_STACK 4'h3
`define VRMC_ADR_AUX 4'h4
`define VRMC_ADR_DIAGNOSTIC_STEP_BITS 4'h5
`define VRMC_B_REQ 0
`define VRMC_B_PER 1
`define VRMC_B_AUXM 2
`define VRMC_B_AUXT 3
`define VRMC_B_CELLT 4
`define VRMC_B_BALT 5
`define VRMC_B_HARDWARE_SELF_CHECK_ENABLE 6
`define VRMC_B_OVLCLR 7
`define VRMC_B_CCEN 8
`define VRMC_F_FILT_LO 9
`define VRMC_F_FILT_HI 11
`define VRMC_S_ACT 0
`define VRMC_S_OVL 1
`define VRMC_S_OVR 2
`define VRMC_S_ACTIVE 3
`define VRMC_RES_W 16
`define VRMC_FRESH_BIT 16
`define VRMC_NRES 4
`define VRMC_FILT_RST 3'h0
`define VRMC_STEP_BASE_NS 1000
`define VRMC_CLK_NS 40
`define VRMC_STEP_BASE_CYC ((`VRMC_STEP_BASE_NS + `VRMC_CLK_NS - 1) / `VRMC_CLK_NS)
`endif

// ---- design/vrmc_pkg.sv ----
// Types shared by the routine mode controller.
package vrmc_pkg;
	typedef enum logic [2:0] {
		VRMC_IDLE, VRMC_SYNC, VRMC_CELL, VRMC_STACK, VRMC_AUXM, VRMC_AUXT, VRMC_CELLT, VRMC_BALT
	} vrmc_step_e;
	typedef enum logic [1:0] {
		VRMC_M_NONE, VRMC_M_DEMAND, VRMC_M_PERIODIC, VRMC_M_OVERRIDE
	} vrmc_mode_e;
endpackage

// ---- design/vrmc_step_timer.sv ----
// Step duration timer: one pulse after the acquisition window of a step.
`timescale 1ns/100ps
`include "vrmc_defs.svh"
module vrmc_step_timer (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Control.
	input wire logic start_i,
	input wire logic [2:0] filt_i,
	// Status.
	output logic done_o
);
	logic [15:0] cnt_r;
	logic run_r;
	wire [15:0] len_w = 16'(`VRMC_STEP_BASE_CYC) << filt_i;
	wire last_w = run_r && (cnt_r == 16'h0001);
	assign done_o = last_w;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_r <= 16'h0000;
			run_r <= 1'b0;
		end else if (start_i) begin
			cnt_r <= len_w;
			run_r <= 1'b1;
		end else if (run_r) begin
			cnt_r <= cnt_r - 16'h0001;
			run_r <= !last_w;
		end
	end
endmodule

// ---- test/vrmc_ctrl_properties.sv ----
// Concurrent checks on the routine mode controller ports.
`timescale 1ns/100ps
module vrmc_ctrl_properties (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [5:2] adr_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic err_o,
	input wire logic override_req_i,
	input wire logic cur_soc_pulse_i,
	input wire logic [2:0] step_o,
	input wire logic [2:0] filt_o,
	input wire logic active_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_cell_end;
		step_o == 3'h2 ##1 step_o != 3'h2;
	endsequence
	sequence s_stat_busy;
		ack_o && !we_i && adr_i == 4'h1 && (dat_o[0] || dat_o[2]);
	endsequence
	a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
	a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("long ack");
	a_no_error: assert property (!err_o) else $error("err raised");
	a_active_step: assert property (step_o != 3'h0 |-> active_o) else $error("step idle flag");
	a_override_abort: assert property (override_req_i |-> ##[1:2] step_o == 3'h0)
		else $error("override kept steps");
	a_sync_wait: assert property (step_o == 3'h1 && $past(step_o) == 3'h1 && !cur_soc_pulse_i
		&& !$past(cur_soc_pulse_i) && !override_req_i |=> step_o inside {3'h0, 3'h1}) else $error("sync left");
	a_cell_stack: assert property (s_cell_end |-> step_o inside {3'h0, 3'h3}) else $error("no stack");
	a_filt_hold: assert property (step_o != 3'h0 && $past(step_o) != 3'h0 |-> $stable(filt_o))
		else $error("filter moved");
	a_status_busy: assert property (s_stat_busy |-> dat_o[3]) else $error("status incoherent");
endmodule
bind vrmc_ctrl vrmc_ctrl_properties chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .override_req_i(override_req_i),
	.cur_soc_pulse_i(cur_soc_pulse_i), .step_o(step_o), .filt_o(filt_o), .active_o(active_o));

// ---- test/vrmc_ctrl_tb_top.sv ----
// Self-checking testbench of the routine mode controller.
`timescale 1ns/100ps
module vrmc_ctrl_tb_top;
	logic clk_i, rst_i, ovr, odone, pulse, cyc, stb, we, ack, err, active;
	logic [15:0] adc;
	logic [5:2] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, q;
	logic [2:0] step, filt;
	logic [7:0] seen;
	int fails = 0;
	int compares = 0;
	`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; $display("BAD %0t got %h exp %h", $time, a, e); end end
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	always @(posedge clk_i) if (step != 3'h0) seen[step] <= 1'b1;
	vrmc_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
		.dat_i(wdat), .dat_o(rdat), .ack_o(ack), .err_o(err), .override_req_i(ovr), .override_done_i(odone),
		.cur_soc_pulse_i(pulse), .adc_data_i(adc), .step_o(step), .filt_o(filt), .active_o(active));
	vrmc_host_model host (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
		.dat_o(wdat), .dat_i(rdat), .ack_i(ack));
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		host.xfer(1'b0, a, 32'h0000_0000, q);
		`CHK(q, e)
	endtask
	task automatic wr(input logic [31:0] d);
		host.xfer(1'b1, 4'h0, d, q);
	endtask
	task automatic wait_act(input logic v);
		int n;
		n = 0;
		while (active !== v && n < 3000) begin
			@(posedge clk_i);
			n++;
		end
		`CHK(active, v)
	endtask
	task automatic pulse_in(input int which);
		if (which == 0) ovr <= 1'b1; else odone <= 1'b1;
		@(posedge clk_i);
		ovr <= 1'b0;
		odone <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask
	task automatic report_and_stop();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		#2_000_000;
		fails++;
		report_and_stop();
	end
	initial begin
		rst_i = 1'b1;
		ovr = 1'b0;
		odone = 1'b0;
		pulse = 1'b0;
		adc = 16'hA5C3;
		seen = 8'h00;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(4'h0, 32'h0000_0000);
		rd(4'h1, 32'h0000_0000);
		rd(4'hF, 32'h0000_0000);
		wr(32'h0000_003C);
		repeat (10) @(posedge clk_i);
		`CHK(active, 1'b0)
		wr(32'h0000_0001);
		rd(4'h1, 32'h0000_0009);
		wr(32'h0000_0005);
		wait_act(1'b0);
		rd(4'h1, 32'h0000_0000);
		rd(4'h2, 32'h0001_A5C3);
		rd(4'h2, 32'h0000_A5C3);
		rd(4'h3, 32'h0001_A5C3);
		rd(4'h4, 32'h0000_0000);
		`CHK(seen[7:4], 4'h0)
		$display("plain demand done");
		adc <= 16'h5A3C;
		seen = 8'h00;
		wr(32'h0000_003D);
		wait_act(1'b0);
		`CHK(seen[7:2], 6'h3F)
		rd(4'h4, 32'h0001_5A3C);
		wr(32'h0000_0101);
		repeat (30) @(posedge clk_i);
		`CHK(step, 3'h1)
		pulse <= 1'b1;
		@(posedge clk_i);
		pulse <= 1'b0;
		repeat (3) @(posedge clk_i);
		`CHK(step, 3'h2)
		wait_act(1'b0);
		wr(32'h0000_0201);
		repeat (5) @(posedge clk_i);
		`CHK(filt, 3'h1)
		wait_act(1'b0);
		$display("optional steps done");
		wr(32'h0000_0001);
		repeat (5) @(posedge clk_i);
		pulse_in(0);
		`CHK(step, 3'h0)
		wr(32'h0000_0005);
		rd(4'h1, 32'h0000_000E);
		pulse_in(1);
		rd(4'h1, 32'h0000_0002);
		wr(32'h0000_0002);
		repeat (40) @(posedge clk_i);
		`CHK(active, 1'b0)
		wr(32'h0000_0082);
		wait_act(1'b1);
		pulse_in(0);
		`CHK(step, 3'h0)
		pulse_in(1);
		wr(32'h0000_0080);
		host.wait_idle();
		wr(32'h0000_0001);
		rd(4'h1, 32'h0000_0009);
		wait_act(1'b0);
		$display("override done");
		report_and_stop();
	end
endmodule

// ---- test/vrmc_host_model.sv ----
// Host microcontroller model: classic Wishbone master with status polling.
`timescale 1ns/100ps
module vrmc_host_model (
	// Clock.
	input wire logic clk_i,
	// Wishbone master.
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [5:2] adr_o,
	output logic [3:0] sel_o,
	output logic [31:0] dat_o,
	input wire logic [31:0] dat_i,
	input wire logic ack_i
);
	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		adr_o = 4'h0;
		sel_o = 4'h0;
		dat_o = 32'h0000_0000;
	end
	// Called just after a rising edge; released data is inverted so stale values never match.
	task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= a;
		sel_o <= 4'hF;
		dat_o <= d;
		@(posedge clk_i);
		while (ack_i !== 1'b1) @(posedge clk_i);
		q = dat_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		dat_o <= ~d;
		@(posedge clk_i);
	endtask
	task automatic wait_idle();
		logic [31:0] s;
		s = 32'h0000_0008;
		while (s[3] !== 1'b0) xfer(1'b0, 4'h1, 32'h0000_0000, s);
	endtask
endmodule
